// file: include/tpg_defs.vh
/*
  Constants for the timer/pulse generator: register byte offsets, control
  field positions, reset values, prescaler codes and period widths.
  Assumes it is included by bare name from the core module.
*/
`ifndef TPG_DEFS_VH
`define TPG_DEFS_VH

// register byte offsets on the AXI4-Lite slave
`define TPG_OFF_CTRL 4'h0
`define TPG_OFF_MODULO_LOW 4'h4
`define TPG_OFF_MODULO_HIGH 4'h8
`define TPG_OFF_STAT 4'hC

// control register field positions
`define TPG_BIT_MODE 0
`define TPG_BIT_RUN 1
`define TPG_BIT_RELOAD 3
`define TPG_BIT_STATIC 4
`define TPG_BIT_PSEL 5
`define TPG_BIT_DRIVE 7
`define TPG_CTRL_WMASK 8'hBB

// status register field positions
`define TPG_BIT_IRQ 0
`define TPG_BIT_TFF 1

// reset values
`define TPG_CTRL_RST 8'h00
`define TPG_MOD_RST 8'h00

// one-hot prescaler codes in modulo_low bits 6..2 and divisor minus one
`define TPG_PSC_256 5'h01
`define TPG_PSC_128 5'h02
`define TPG_PSC_64 5'h04
`define TPG_PSC_32 5'h08
`define TPG_PSC_16 5'h10
`define TPG_DIV_256 8'hFF
`define TPG_DIV_128 8'h7F
`define TPG_DIV_64 8'h3F
`define TPG_DIV_32 8'h1F
`define TPG_DIV_16 8'h0F

// pwm periods: basic 2^10 clocks, secondary 2^15 clocks (32 basic)
`define TPG_BASIC_BITS 10
`define TPG_SEC_BITS 5

// axi responses
`define TPG_RESP_OKAY 2'b00
`define TPG_RESP_SLVERR 2'b10

`endif

// file: core/tpg_core.v
/*
  Timer/pulse generator with an AXI4-Lite register slave. Timer mode runs
  a prescaled 8-bit interval timer and toggles a square wave; PWM mode
  makes an active-low 14-bit pulse from a double-buffered modulo latch.
  Assumes one clock aclk (25 MHz), synchronous active-low aresetn, and a
  testbench that resolves the pin from pin_out and pin_oe_n.
*/
// Local design decisions: the AXI4-Lite slave port and the register addresses.
// How it works
// - control bit 0 high picks timer mode, low picks pwm mode.
// - timer takes prescaler from modulo_low and count N from modulo_high.
// - timer counts only while run enable is one.
// - one-hot modulo_low bits 6..2 pick 256..16; interval divisor*(N+1).
// - square wave toggles once per interval.
// - pin carries waveform only when pulse select and drive are one.
// - stopping the timer sets the toggle flop, possibly the flag.
// - pwm mode raises the flag every 2^15 clocks.
// - pwm output is active low, low time set by 14-bit latch.
// - pwm uses 2^10 basic period inside a 2^15 secondary period.
// - latch holds modulo_high above modulo_low bits 7..2.
// - all 14 latch bits copy at once while reload is enabled.
// - low two bits of modulo_low read back as don't-care.
// - latch changes inside a basic period do not alter its pulse.
// - pulse select zero with drive one puts static level on pin.
// - reset clears control: disabled, pwm mode, pin undriven.
// - drive enable zero leaves the pin in high impedance.
`timescale 1ns/1ns
`include "tpg_defs.vh"

module tpg_core #(
  parameter BASIC_BITS = `TPG_BASIC_BITS,
  parameter SEC_BITS = `TPG_SEC_BITS
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg pulse_output_pin,
  output reg pulse_output_pin_oe_n,
  output wire pulse_gen_irq_flag
);

  // one counter spans the whole secondary period
  localparam CNT_BITS = BASIC_BITS + SEC_BITS;

  // divisor minus one for a one-hot prescaler code; illegal codes use 256
  function [7:0] psc_div;
    input [4:0] code;
    begin
      case (code)
        `TPG_PSC_256: psc_div = `TPG_DIV_256;
        `TPG_PSC_128: psc_div = `TPG_DIV_128;
        `TPG_PSC_64: psc_div = `TPG_DIV_64;
        `TPG_PSC_32: psc_div = `TPG_DIV_32;
        `TPG_PSC_16: psc_div = `TPG_DIV_16;
        default: psc_div = `TPG_DIV_256;
      endcase
    end
  endfunction

  // registers
  reg [7:0] ctrl_r;
  reg [7:0] modulo_low_r;
  reg [7:0] modulo_high_r;
  reg [13:0] latch_r;
  reg irq_r;
  reg tff_r;
  reg run_d_r;
  reg [7:0] psc_r;
  reg [7:0] tcnt_r;
  reg [CNT_BITS-1:0] pcnt_r;
  // one bit wider than the position so a fully low period still fits
  reg [BASIC_BITS:0] low_r;

  // axi write side holding registers
  reg aw_held_r;
  reg [3:0] aw_addr_r;
  reg w_held_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;

  wire mode_timer = ctrl_r[`TPG_BIT_MODE];
  wire run = ctrl_r[`TPG_BIT_RUN];
  wire reload_en = ctrl_r[`TPG_BIT_RELOAD];
  wire psel = ctrl_r[`TPG_BIT_PSEL];
  wire drive = ctrl_r[`TPG_BIT_DRIVE];

  // plain register output; routing it to an interrupt is done elsewhere
  assign pulse_gen_irq_flag = irq_r;

  // the write response must drain before another address or data beat
  // is accepted; this keeps one write in flight and needs no skid
  // registers beyond the single held beat per channel
  // address and data are taken independently, one write in flight
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire aw_ok = aw_held_r | aw_hs;
  wire w_ok = w_held_r | w_hs;
  wire [3:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
  wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  wire wr_do = aw_ok & w_ok & ~s_axi_bvalid;
  wire wr_lane = wr_do & wr_strb[0];
  wire wr_ctrl = wr_lane & (wr_addr == `TPG_OFF_CTRL);
  wire wr_modulo_low = wr_lane & (wr_addr == `TPG_OFF_MODULO_LOW);
  wire wr_modulo_high = wr_lane & (wr_addr == `TPG_OFF_MODULO_HIGH);
  wire wr_stat = wr_lane & (wr_addr == `TPG_OFF_STAT);
  wire wr_mapped = (wr_addr == `TPG_OFF_CTRL) | (wr_addr == `TPG_OFF_MODULO_LOW) |
                   (wr_addr == `TPG_OFF_MODULO_HIGH) | (wr_addr == `TPG_OFF_STAT);

  // write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPG_RESP_OKAY;
    end else begin
      // both halves present: commit and answer; otherwise park what came
      if (wr_do) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
      end else begin
        if (aw_hs) begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_hs) begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // rdata loads only when an address is taken and then stands untouched
  // until rready, so a slow master never sees it move
  // read channel; address bits 1:0 are ignored (word aligned)
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TPG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TPG_RESP_OKAY;
      case (s_axi_araddr & 4'hC)
        `TPG_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl_r};
        // low two bits read as zero, software must not rely on them
        `TPG_OFF_MODULO_LOW: s_axi_rdata <= {24'h000000, modulo_low_r[7:2], 2'b00};
        `TPG_OFF_MODULO_HIGH: s_axi_rdata <= {24'h000000, modulo_high_r};
        // status: toggle flop above the interval flag
        `TPG_OFF_STAT: s_axi_rdata <= {30'h00000000, tff_r, irq_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `TPG_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // modulo registers take any byte: illegal prescaler codes and a zero
  // modulo_high are not refused here, software keeps them legal
  // software registers; unused control bits 2 and 6 stay zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `TPG_CTRL_RST;
      modulo_low_r <= `TPG_MOD_RST;
      modulo_high_r <= `TPG_MOD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wr_data[7:0] & `TPG_CTRL_WMASK;
      end
      if (wr_modulo_low) begin
        modulo_low_r <= wr_data[7:0];
      end
      if (wr_modulo_high) begin
        modulo_high_r <= wr_data[7:0];
      end
    end
  end

  // with reload left on (timer mode needs it) the latch trails the
  // registers by one cycle, so a pwm user writing both halves with reload
  // on may see one mixed value for a period; drop reload while writing
  // modulo latch: all 14 bits at once, copied from the registers every cycle reload is on
  always @(posedge aclk) begin
    if (!aresetn) begin
      latch_r <= 14'h0000;
    end else if (reload_en) begin
      latch_r <= {modulo_high_r, modulo_low_r[7:2]};
    end
  end

  // illegal prescaler codes fall back to the slowest divisor rather than
  // stalling the timer; the count compares against the latch, so a new N
  // is picked up without restarting the interval
  // timer mode: prescaler tick, then interval counter 0..N
  wire [7:0] div_m1 = psc_div(modulo_low_r[6:2]);
  wire [7:0] tmr_n = latch_r[13:6];
  wire tmr_run = run & mode_timer;
  wire tick = tmr_run & (psc_r == div_m1);
  wire tmr_wrap = tick & (tcnt_r == tmr_n);
  wire tmr_stop = run_d_r & ~run & mode_timer;

  // the top five counter bits name the basic period inside the secondary
  // period, the low bits the position inside that basic period
  // pwm mode: free counter over one secondary period
  wire pwm_run = run & ~mode_timer;
  wire [BASIC_BITS-1:0] bpos = pcnt_r[BASIC_BITS-1:0];
  wire [SEC_BITS-1:0] bidx = pcnt_r[CNT_BITS-1:BASIC_BITS];
  wire basic_end = pwm_run & (&bpos);
  wire sec_end = pwm_run & (&pcnt_r);
  // index of the period whose width is sampled next; while stopped the
  // counter rests at zero and the first period to run is period 0
  wire [SEC_BITS-1:0] next_idx = pwm_run ?
    bidx + {{(SEC_BITS-1){1'b0}}, 1'b1} : {SEC_BITS{1'b0}};

  // low width of the coming basic period: 4*H, plus 4 in the first
  // lo[5:1] periods, plus 2 in the last period when lo[0] is set, so a
  // secondary period holds 2*latch low clocks in total
  reg [BASIC_BITS+1:0] low_calc;
  always @* begin
    low_calc = {{(BASIC_BITS-8){1'b0}}, latch_r[13:6], 2'b00};
    if (next_idx < latch_r[5:1]) begin
      low_calc = low_calc + {{(BASIC_BITS-1){1'b0}}, 3'h4};
    end
    if (latch_r[0] && (&next_idx)) begin
      low_calc = low_calc + {{(BASIC_BITS-1){1'b0}}, 3'h2};
    end
  end
  wire [BASIC_BITS:0] low_sat = low_calc[BASIC_BITS+1] ?
    {1'b1, {BASIC_BITS{1'b0}}} : low_calc[BASIC_BITS:0];

  // active-low pwm level; high while stopped
  wire pwm_level = ~(pwm_run & ({1'b0, bpos} < low_r));

  // flag set strobe: timer wrap, end of a secondary period, or a stop
  // that forces a low toggle flop high
  wire pulse_gen_irq_set = tmr_wrap | sec_end | (tmr_stop & ~tff_r);
  // software clear: a one written to the status flag bit
  wire irq_clr = wr_stat & wr_data[`TPG_BIT_IRQ];

  // counters, toggle flop and interval flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      psc_r <= 8'h00;
      tcnt_r <= 8'h00;
      pcnt_r <= {CNT_BITS{1'b0}};
      low_r <= {(BASIC_BITS+1){1'b0}};
      tff_r <= 1'b0;
      run_d_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      // previous run level, used to spot a timer stop
      run_d_r <= run;
      // prescaler and interval counter, cleared while stopped
      if (!tmr_run) begin
        psc_r <= 8'h00;
        tcnt_r <= 8'h00;
      end else if (tick) begin
        psc_r <= 8'h00;
        tcnt_r <= tmr_wrap ? 8'h00 : tcnt_r + 8'h01;
      end else begin
        psc_r <= psc_r + 8'h01;
      end
      // stop forces the toggle flop high; a rising flop counts as a toggle
      if (tmr_stop) begin
        tff_r <= 1'b1;
      end else if (tmr_wrap) begin
        tff_r <= ~tff_r;
      end
      // pwm counter and low width sampled once per basic period
      if (!pwm_run) begin
        pcnt_r <= {CNT_BITS{1'b0}};
        low_r <= low_sat;
      end else begin
        pcnt_r <= pcnt_r + {{(CNT_BITS-1){1'b0}}, 1'b1};
        if (basic_end) begin
          low_r <= low_sat;
        end
      end
      // the set wins over a software clear in the same cycle, so an
      // event that lands on the clearing write is never lost
      if (pulse_gen_irq_set) begin
        irq_r <= 1'b1;
      end else if (irq_clr) begin
        irq_r <= 1'b0;
      end
    end
  end

  // the level is registered so it never glitches on a control write;
  // with drive off the level still follows, only the enable is withdrawn
  // pin: waveform, static level or high impedance
  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_output_pin <= 1'b0;
      pulse_output_pin_oe_n <= 1'b1;
    end else begin
      pulse_output_pin_oe_n <= ~drive;
      if (psel) begin
        pulse_output_pin <= mode_timer ? tff_r : pwm_level;
      end else begin
        pulse_output_pin <= ctrl_r[`TPG_BIT_STATIC];
      end
    end
  end

endmodule // tpg_core

// file: verification/tpg_pin_model.sv
/* pin-side stand-in for the filter on the pulse pin: resolves the line
   and integrates its low time. assumes the core clock; no pull on pin. */
`timescale 1ns/1ns
module tpg_pin_model (
  input wire aclk,
  input wire pulse_output_pin,
  input wire pulse_output_pin_oe_n,
  output wire level,
  output reg [31:0] low_cnt_r = 32'h0
);
  reg last_r = 1'h0;
  // released line flips each cycle so it never passes for a held level
  assign level = pulse_output_pin_oe_n ? ~last_r : pulse_output_pin;
  // low time counts only while the core drives the line
  always @(posedge aclk) begin
    last_r <= level;
    if (!pulse_output_pin_oe_n && !pulse_output_pin)
      low_cnt_r <= low_cnt_r + 32'h1;
  end
endmodule // tpg_pin_model

// file: verification/tpg_core_monitor.sv
/* port checker for tpg_core, bound into it at the foot of this file.
   assumes a control write hands over address and data at one edge. */
`timescale 1ns/1ns
module tpg_core_monitor (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire pulse_output_pin,
  input wire pulse_output_pin_oe_n,
  input wire pulse_gen_irq_flag
);
  reg [7:0] ctl_r;
  wire wr_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready;
  // shadow of control; bits 2 and 6 never store
  always @(posedge aclk) begin
    if (!aresetn)
      ctl_r <= 8'h00;
    else if (wr_go && s_axi_awaddr == 4'h0 && s_axi_wstrb[0])
      ctl_r <= s_axi_wdata[7:0] & 8'hBB;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  hiz_follow_a: assert property (
    !$past(ctl_r[7]) |-> pulse_output_pin_oe_n)
    else $error("pin driven with drive off");
  static_level_a: assert property (
    $past(ctl_r[7] && !ctl_r[5]) |->
      !pulse_output_pin_oe_n && pulse_output_pin == $past(ctl_r[4]))
    else $error("static level wrong");
  reset_clear_a: assert property (
    $rose(aresetn) |-> pulse_output_pin_oe_n && !pulse_gen_irq_flag)
    else $error("outputs not cleared by reset");
  idle_high_a: assert property (
    (ctl_r[7] && ctl_r[5] && ctl_r[1:0] == 2'h0) [*3] |-> pulse_output_pin)
    else $error("stopped pwm not high");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  write_answer_a: assert property (wr_go |=> s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule // tpg_core_monitor
bind tpg_core tpg_core_monitor mon_u (.*);

// file: verification/tb_top.sv
/* self-checking bench for tpg_core: registers, static pin, timer
   intervals, pwm period and duty. assumes tpg_defs.vh on the include
   path and the pin model and monitor compiled first. */
`timescale 1ns/1ns
`include "tpg_defs.vh"
module tb_top;
  reg aclk = 1'h0;
  reg aresetn = 1'h0;
  reg [3:0] s_axi_awaddr = 4'h0;
  reg [3:0] s_axi_araddr = 4'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_awvalid = 1'h0;
  reg s_axi_wvalid = 1'h0;
  reg s_axi_bready = 1'h0;
  reg s_axi_arvalid = 1'h0;
  reg s_axi_rready = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, pulse_output_pin, pulse_output_pin_oe_n;
  wire pulse_gen_irq_flag, level;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, low_cnt_r;
  integer failures = 0;
  integer n_checks = 0;
  integer cyc = 0;

  tpg_core dut_u (.*);
  tpg_pin_model pin_u (.*);

  // 25 MHz clock
  initial forever #20 aclk = ~aclk;

  // hang guard; the full run needs about 69k cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures = failures + 1;
      print_verdict;
    end
  end

  task chk(input [31:0] got, input [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task print_verdict;
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // axi-lite write; each channel drops once taken
  task wr(input [3:0] a, input [7:0] d);
    reg aw, w;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (aw || w) begin
      @(posedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    chk(s_axi_bresp, 32'h0);
    s_axi_bready <= 1'h0;
  endtask

  // axi-lite read; late rready exercises the hold of rdata
  task rd(input [3:0] a, output [7:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    d = s_axi_rdata[7:0];
    chk(s_axi_rresp, 32'h0);
    s_axi_rready <= 1'h0;
  endtask

  // cycles between two successive pin changes
  task gap(output integer n);
    reg p;
    @(posedge aclk);
    p = pulse_output_pin;
    while (pulse_output_pin === p) @(posedge aclk);
    p = pulse_output_pin;
    n = 0;
    while (pulse_output_pin === p) begin
      @(posedge aclk);
      n = n + 1;
    end
  endtask

  task wait_irq;
    do @(posedge aclk); while (pulse_gen_irq_flag !== 1'h1);
  endtask

  task t_reset;
    reg [7:0] d;
    rd(`TPG_OFF_CTRL, d);
    chk(d, 32'h0);
    chk(pulse_output_pin_oe_n, 32'h1);
    chk(pulse_gen_irq_flag, 32'h0);
  endtask

  // low two bits of modulo_low are masked off before comparing
  task t_regs;
    reg [7:0] d;
    wr(`TPG_OFF_MODULO_LOW, 8'hFF);
    rd(`TPG_OFF_MODULO_LOW, d);
    chk(d & 8'hFC, 32'hFC);
    wr(`TPG_OFF_MODULO_HIGH, 8'hA5);
    rd(`TPG_OFF_MODULO_HIGH, d);
    chk(d, 32'hA5);
    // a write with byte lane 0 off must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(`TPG_OFF_MODULO_HIGH, 8'h5A);
    s_axi_wstrb <= 4'hF;
    rd(`TPG_OFF_MODULO_HIGH, d);
    chk(d, 32'hA5);
    wr(`TPG_OFF_CTRL, 8'h4C);
    rd(`TPG_OFF_CTRL, d);
    chk(d, 32'h08);
  endtask

  // static high, static low, stopped pwm, drive off
  task t_static;
    reg [31:0] tbl;
    reg [7:0] c;
    integer i;
    tbl = 32'h10A08090;
    for (i = 0; i < 4; i = i + 1) begin
      c = tbl[8*i +: 8];
      wr(`TPG_OFF_CTRL, c);
      repeat (3) @(posedge aclk);
      chk({pulse_output_pin_oe_n, level & c[7]},
        {~c[7], (c[4] | c[5]) & c[7]});
    end
  endtask

  // every prescaler code with its own N, then stop and clear the flag
  task t_timer;
    reg [7:0] d;
    integer i, n;
    wr(`TPG_OFF_CTRL, 8'hA9);
    for (i = 0; i < 5; i = i + 1) begin
      wr(`TPG_OFF_MODULO_HIGH, 8'h01 + i[7:0]);
      wr(`TPG_OFF_MODULO_LOW, 8'h04 << i);
      wr(`TPG_OFF_CTRL, 8'hAB);
      gap(n);
      chk(n, (256 >> i) * (i + 2));
      chk(pulse_gen_irq_flag, 32'h1);
      wr(`TPG_OFF_CTRL, 8'hA9);
      rd(`TPG_OFF_STAT, d);
      chk(d[1], 32'h1);
      wr(`TPG_OFF_STAT, 8'h01);
      rd(`TPG_OFF_STAT, d);
      chk(d[0], 32'h0);
    end
  endtask

  // latch 0x1021: one secondary period between flags
  task t_pwm;
    integer c0, l0;
    wr(`TPG_OFF_MODULO_HIGH, 8'h40);
    wr(`TPG_OFF_MODULO_LOW, 8'h84);
    wr(`TPG_OFF_CTRL, 8'hAA);
    wr(`TPG_OFF_STAT, 8'h01);
    wait_irq;
    c0 = cyc;
    l0 = low_cnt_r;
    wr(`TPG_OFF_STAT, 8'h01);
    wait_irq;
    chk(cyc - c0, 32768);
    chk(low_cnt_r - l0, 2 * 4129);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset;
    t_regs;
    t_static;
    t_timer;
    t_pwm;
    print_verdict;
  end
endmodule // tb_top
